// >>> include/ita_pkg.sv
// Purpose: Shared constants and types for the serial register target
// Assumes: Register bank is byte wide with an 8-bit sub-address
// Notes: Link side runs on the bus clock, core side on clk
package ita_pkg;

    // Fixed upper six bits of the 7-bit target address
    localparam logic [5:0] TGT_ADDR_UPPER = 6'h16;
    // Sub-address used when no write has set one
    localparam logic [7:0] SUB_ADDR_RESET = 8'h00;
    // Identification bytes occupy the bottom of the map
    localparam logic [7:0] IDENT_LAST = 8'h08;
    localparam int IDENT_COUNT = 9;
    // Register bank size, one entry per sub-address value
    localparam int REG_COUNT = 256;
    // Bit counter positions inside one byte frame on the link
    localparam logic [3:0] LINK_LAST_BIT = 4'h7;
    localparam logic [3:0] LINK_ACK_BIT = 4'h8;
    localparam logic [3:0] LINK_CNT_RESET = 4'h0;
    // Highest bus rate the target is specified for, in kbps
    localparam int FAST_MODE_KBPS = 400;
    // Core clock rate, in kHz, and the resulting oversampling ratio
    localparam int CORE_CLK_KHZ = 100000;
    localparam int CLKS_PER_BIT = CORE_CLK_KHZ / FAST_MODE_KBPS;

    // Transaction sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SUB,
        ST_WDATA,
        ST_ACK_WAIT,
        ST_ACK_HOLD,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } ita_state_t;

    // State on the bus clock side
    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic tgl;
    } ita_link_t;

endpackage : ita_pkg

// >>> design/ita_target.sv
// Purpose: Byte-wide serial target giving a bus master access to the
//          control_status_bank of the bridge
// Assumes: scl is the master's bus clock; clk is unrelated to it
// Notes: Receive shifting runs on scl; sequencing and the bank on clk
`timescale 1ns/100ps

// Summary of operation
// RL1 - Answer only while chip enable is high; bank stays reachable in ULPS.
// RL2 - Standard two-wire signalling, fast mode up to 400 kbps.
// RL3 - First byte after START is target address plus direction bit.
// RL4 - Target address is 010110X, X taken from the target select input.
// RL5 - Select high gives 0x5A/0x5B, select low gives 0x58/0x59.
// RL6 - Write: START, address with direction zero, target acknowledges.
// RL7 - Next byte is the sub-address, MSB first, acknowledged.
// RL8 - Any number of data bytes follow, each one acknowledged.
// RL9 - Master ends a write with STOP after the last acknowledge.
// RL10 - Read: START, address with direction one, target acknowledges.
// RL11 - Read sends MSB first from 00h or the last written sub-address.
// RL12 - After each sent byte wait for master ACK; ACK sends next byte.
// RL13 - Master ends a read with STOP.
// RL14 - Address plus sub-address then STOP sets the next read start.
// RL15 - Every bank register is reachable by its access type.
// RL16 - Software leaves reserved fields unchanged.
// RL17 - Locations 0x00 to 0x08 are fixed read-only identification bytes.
// RL18 - Write-only bits read as zero; one-to-clear bits clear on a one.
// RL19 - Sub-address advances after every data byte, read or write.
// RL20 - No acknowledge for another address; master NACK ends sending.
module ita_target #(
    // Identification bytes, byte n at bits n*8+7:n*8; values arbitrary
    parameter logic [ita_pkg::IDENT_COUNT*8-1:0] ID_BYTES =
        72'h12_11_10_0f_0e_0d_0c_0b_0a,
    // Reset image of the whole bank; the identification range is ignored
    parameter logic [ita_pkg::REG_COUNT-1:0][7:0] RESET_IMAGE = '0,
    // Registers of write_one_clear_access type, one flag per register
    parameter logic [ita_pkg::REG_COUNT-1:0] W1C_REGS = '0,
    // Write-only registers, one flag per register
    parameter logic [ita_pkg::REG_COUNT-1:0] WO_REGS = '0
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial bus pins; scl also clocks the receive shifter
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Device pins
    input wire logic chip_en,
    input wire logic tgt_sel,
    // Bank contents to the rest of the bridge, and hardware status sets
    output logic [ita_pkg::REG_COUNT-1:0][7:0] csr_q,
    input wire logic [ita_pkg::REG_COUNT-1:0][7:0] status_set
);

    ////////////////////////////////////////////////////////////////////////
    // Core state
    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        ita_pkg::ita_state_t state;
        ita_pkg::ita_state_t after_ack;
        logic link_rst;
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [1:0] en_sy;
        logic [1:0] sel_sy;
        logic [1:0] tgl_sy;
        logic tgl_seen;
        logic byte_done;
        logic mack;
        logic [7:0] tx_byte;
        logic [7:0] sub_addr;
        logic sda_oe;
        logic sda_o;
        logic [ita_pkg::REG_COUNT-1:0][7:0] bank;
    } ita_core_t;

    // Identification bytes overlay the bottom of the reset image
    localparam logic [ita_pkg::REG_COUNT-1:0][7:0] BANK_INIT =
        {RESET_IMAGE[ita_pkg::REG_COUNT-1:ita_pkg::IDENT_COUNT], ID_BYTES};

    localparam ita_core_t CORE_INIT = '{
        state: ita_pkg::ST_IDLE,
        after_ack: ita_pkg::ST_IDLE,
        link_rst: 1'b1,
        // Idle bus level, so no false edge follows reset
        scl_sy: 3'h7,
        sda_sy: 3'h7,
        sub_addr: ita_pkg::SUB_ADDR_RESET,
        bank: BANK_INIT,
        default: '0
    };

    ita_core_t c_reg;
    ita_core_t c_next;
    ita_pkg::ita_link_t l_reg;
    ita_pkg::ita_link_t l_next;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_evt;
    logic [7:0] rx_byte;
    logic [7:0] rd_data;
    logic [ita_pkg::REG_COUNT-1:0][7:0] set_mask;

    ////////////////////////////////////////////////////////////////////////
    // Link side: bit shifter on the bus clock
    ////////////////////////////////////////////////////////////////////////

    // Shift on each rising edge, skip the ninth (acknowledge) bit
    always_comb begin
        l_next = l_reg;
        if (l_reg.cnt == ita_pkg::LINK_ACK_BIT) begin
            l_next.cnt = ita_pkg::LINK_CNT_RESET;
        end else begin
            l_next.shreg = {l_reg.shreg[6:0], sda_i}; // RL7
            l_next.cnt = l_reg.cnt + 4'h1;
            // Toggle marks a full byte; data stays put until next rise
            if (l_reg.cnt == ita_pkg::LINK_LAST_BIT) begin
                l_next.tgl = ~l_reg.tgl;
            end
        end
    end

    // Held in reset by the core outside frames; scl may stop at any time
    always_ff @(posedge scl or posedge c_reg.link_rst) begin
        if (c_reg.link_rst) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core side: bus conditions and byte events
    ////////////////////////////////////////////////////////////////////////

    // Edges taken from second and third stages, never the first
    assign scl_rise = c_reg.scl_sy[1] & ~c_reg.scl_sy[2];
    assign scl_fall = ~c_reg.scl_sy[1] & c_reg.scl_sy[2];
    // START and STOP: data moves while clock stays high
    assign bus_start = c_reg.scl_sy[1] & c_reg.scl_sy[2]
        & ~c_reg.sda_sy[1] & c_reg.sda_sy[2]; // RL3
    assign bus_stop = c_reg.scl_sy[1] & c_reg.scl_sy[2]
        & c_reg.sda_sy[1] & ~c_reg.sda_sy[2]; // RL9
    // Byte ready once the synchronised toggle differs from the last one
    assign byte_evt = (c_reg.tgl_sy[1] != c_reg.tgl_seen) & ~c_reg.link_rst;
    // Received byte is stable while scl is low after the eighth rise
    assign rx_byte = l_reg.shreg;

    // Read value: write-only registers give zero rather than stale data
    assign rd_data = WO_REGS[c_reg.sub_addr] ? 8'h00
        : c_reg.bank[c_reg.sub_addr]; // RL18

    // Hardware status sets only reach one-to-clear registers
    generate
        for (genvar i = 0; i < ita_pkg::REG_COUNT; i++) begin : g_set
            assign set_mask[i] = status_set[i] & {8{W1C_REGS[i]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Core side: sequencer and register bank
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        c_next = c_reg;
        // Synchronisers for pins crossing into clk
        c_next.scl_sy = {c_reg.scl_sy[1:0], scl};
        c_next.sda_sy = {c_reg.sda_sy[1:0], sda_i};
        c_next.en_sy = {c_reg.en_sy[0], chip_en};
        c_next.sel_sy = {c_reg.sel_sy[0], tgt_sel};
        c_next.tgl_sy = {c_reg.tgl_sy[0], l_reg.tgl};
        c_next.tgl_seen = c_reg.tgl_sy[1];
        c_next.sda_o = 1'b0;

        if (!c_reg.en_sy[1]) begin
            // Disabled: release the bus and hold the shifter
            c_next.state = ita_pkg::ST_IDLE; // RL1
            c_next.sda_oe = 1'b0;
            c_next.link_rst = 1'b1;
        end else if (bus_start) begin
            // Also covers a repeated START inside a transaction
            c_next.state = ita_pkg::ST_ADDR; // RL3
            c_next.sda_oe = 1'b0;
            c_next.link_rst = 1'b1;
        end else if (bus_stop) begin
            // Sub-address is kept across STOP for a later read
            c_next.state = ita_pkg::ST_IDLE; // RL14
            c_next.sda_oe = 1'b0;
            c_next.link_rst = 1'b1;
        end else begin
            // Free the shifter once scl is low after START
            if (c_reg.link_rst && c_reg.state == ita_pkg::ST_ADDR
                    && !c_reg.scl_sy[1]) begin
                c_next.link_rst = 1'b0;
            end
            case (c_reg.state)
                ita_pkg::ST_IDLE: begin
                    c_next.sda_oe = 1'b0;
                end
                ita_pkg::ST_ADDR: begin
                    if (byte_evt) begin
                        // Match 010110 plus the select strap
                        if (rx_byte[7:1] == {ita_pkg::TGT_ADDR_UPPER,
                                c_reg.sel_sy[1]}) begin // RL4 RL5
                            c_next.state = ita_pkg::ST_ACK_WAIT;
                            if (rx_byte[0]) begin
                                c_next.after_ack = ita_pkg::ST_TX; // RL10
                            end else begin
                                c_next.after_ack = ita_pkg::ST_SUB; // RL6
                            end
                        end else begin
                            c_next.state = ita_pkg::ST_IGNORE; // RL20
                        end
                    end
                end
                ita_pkg::ST_SUB: begin
                    if (byte_evt) begin
                        c_next.sub_addr = rx_byte; // RL7 RL14
                        c_next.after_ack = ita_pkg::ST_WDATA;
                        c_next.state = ita_pkg::ST_ACK_WAIT;
                    end
                end
                ita_pkg::ST_WDATA: begin
                    if (byte_evt) begin
                        // Identification range ignores writes
                        if (c_reg.sub_addr > ita_pkg::IDENT_LAST) begin // RL17
                            if (W1C_REGS[c_reg.sub_addr]) begin
                                c_next.bank[c_reg.sub_addr] =
                                    c_reg.bank[c_reg.sub_addr]
                                    & ~rx_byte; // RL18
                            end else begin
                                c_next.bank[c_reg.sub_addr] = rx_byte; // RL15
                            end
                        end
                        c_next.sub_addr = c_reg.sub_addr + 8'h01; // RL19
                        c_next.after_ack = ita_pkg::ST_WDATA;
                        c_next.state = ita_pkg::ST_ACK_WAIT; // RL8
                    end
                end
                ita_pkg::ST_ACK_WAIT: begin
                    // Pull data low only once scl has gone low
                    if (scl_fall) begin
                        c_next.sda_oe = 1'b1; // RL6 RL7 RL8
                        c_next.state = ita_pkg::ST_ACK_HOLD;
                    end
                end
                ita_pkg::ST_ACK_HOLD: begin
                    if (scl_fall) begin
                        if (c_reg.after_ack == ita_pkg::ST_TX) begin
                            // First read byte goes out on this same fall
                            c_next.sda_oe = ~rd_data[7]; // RL11
                            c_next.tx_byte = {rd_data[6:0], 1'b0};
                            c_next.byte_done = 1'b0;
                        end else begin
                            c_next.sda_oe = 1'b0;
                        end
                        c_next.state = c_reg.after_ack;
                    end
                end
                ita_pkg::ST_TX: begin
                    if (byte_evt) begin
                        c_next.byte_done = 1'b1;
                    end
                    if (scl_fall) begin
                        if (c_reg.byte_done) begin
                            // Release for the master's acknowledge
                            c_next.sda_oe = 1'b0;
                            c_next.sub_addr = c_reg.sub_addr + 8'h01; // RL19
                            c_next.state = ita_pkg::ST_MACK;
                        end else begin
                            c_next.sda_oe = ~c_reg.tx_byte[7]; // RL11
                            c_next.tx_byte = {c_reg.tx_byte[6:0], 1'b0};
                        end
                    end
                end
                ita_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        c_next.mack = ~c_reg.sda_sy[1]; // RL12
                    end
                    if (scl_fall) begin
                        if (c_reg.mack) begin
                            c_next.sda_oe = ~rd_data[7]; // RL12
                            c_next.tx_byte = {rd_data[6:0], 1'b0};
                            c_next.byte_done = 1'b0;
                            c_next.state = ita_pkg::ST_TX;
                        end else begin
                            // NACK: stay off the bus until STOP or START
                            c_next.sda_oe = 1'b0; // RL20
                            c_next.state = ita_pkg::ST_IGNORE; // RL13
                        end
                    end
                end
                ita_pkg::ST_IGNORE: begin
                    c_next.sda_oe = 1'b0; // RL20
                end
                default: begin
                    c_next.state = ita_pkg::ST_IDLE;
                    c_next.sda_oe = 1'b0;
                end
            endcase
        end

        // Hardware set applied after any clear, so a set is never lost
        c_next.bank = c_next.bank | set_mask; // RL18
    end

    // Single register stage for all core state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c_reg <= CORE_INIT;
        end else begin
            c_reg <= c_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    ////////////////////////////////////////////////////////////////////////

    assign sda_oe = c_reg.sda_oe;
    assign sda_o = c_reg.sda_o;
    assign csr_q = c_reg.bank;

endmodule : ita_target

// >>> tb/ita_checker.sv
// Purpose: Pin-level assertions for the serial register target
// Assumes: Pins are synchronised here much as the core does it
// Notes: Slot flags lag the pins by three clk; bus bits are far longer
`timescale 1ns/100ps
module ita_checker #(
    parameter logic [ita_pkg::IDENT_COUNT*8-1:0] ID_BYTES = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial pins
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Device pins and bank
    input wire logic chip_en,
    input wire logic tgt_sel,
    input wire logic [ita_pkg::REG_COUNT-1:0][7:0] csr_q
);
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [3:0] cnt;
    logic [7:0] shr;
    logic first, rd, quiet, rise, cond;
    ////////////////////////////////////////////////////////////
    // Synced scl rise; any sda edge with scl high is START or STOP
    assign rise = scl_s[1] && !scl_s[2];
    assign cond = scl_s[1] && scl_s[2] && (sda_s[1] != sda_s[2]);
    // Slot tracker; quiet marks idle, a foreign address or a read NACK
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            cnt <= 4'h0;
            shr <= 8'h00;
            first <= 1'b1;
            rd <= 1'b0;
            quiet <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl};
            sda_s <= {sda_s[1:0], sda_i};
            if (cond) begin
                cnt <= 4'h0;
                first <= 1'b1;
                rd <= 1'b0;
                quiet <= sda_s[1];
            end else if (rise) begin
                shr <= {shr[6:0], sda_s[1]};
                cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
                if (cnt == 4'h8) begin
                    first <= 1'b0;
                end
                if (cnt == 4'h7 && first) begin
                    rd <= sda_s[1];
                end
                if (cnt == 4'h7 && first &&
                    shr[6:0] != {ita_pkg::TGT_ADDR_UPPER, tgt_sel}) begin
                    quiet <= 1'b1;
                end
                if (cnt == 4'h8 && rd && !first && sda_s[1]) begin
                    quiet <= 1'b1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Disabled for a while, and an output standing for a while
    sequence off_s;
        !chip_en [*6];
    endsequence
    sequence held_s;
        sda_oe [*8];
    endsequence
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("sda_o not held low");
    ident_fixed_a: assert property (csr_q[8:0] == ID_BYTES)
        else $error("identification bytes changed");
    disabled_quiet_a: assert property (off_s |-> !sda_oe)
        else $error("bus driven while disabled");
    oe_in_low_a: assert property (
        $changed(sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
        else $error("sda_oe moved near scl high");
    ack_slot_a: assert property (
        $rose(sda_oe) && !rd |-> cnt == 4'h8)
        else $error("write ack outside ninth slot");
    ack_hold_a: assert property ($rose(sda_oe) |-> held_s)
        else $error("driven level too short");
    quiet_bus_a: assert property ($rose(sda_oe) |-> !quiet)
        else $error("driven after foreign address or NACK");
    rd_release_a: assert property (
        rise && cnt == 4'h8 && rd && !first |-> !sda_oe)
        else $error("master ack slot not released");
    csr_write_a: assert property (
        $changed(csr_q) |-> !rd && !quiet && !first)
        else $error("bank changed outside a write");
endmodule : ita_checker

bind ita_target ita_checker #(.ID_BYTES(ID_BYTES)) i_chk (
    .clk(clk), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .chip_en(chip_en), .tgt_sel(tgt_sel), .csr_q(csr_q)
);

// >>> tb/ita_master.sv
// Purpose: Bus master model driving the serial target's pins
// Assumes: sda is the resolved wire with a pull-up
// Notes: scl rests high between frames; a phase is two lclk periods
`timescale 1ns/100ps
module ita_master (
    // Bus pins
    output logic scl,
    output logic sda_low,
    // Resolved data wire
    input wire logic sda
);
    logic lclk = 1'b0;
    // 125 ns base; 250 ns phases give 500 ns bits, five times the fast-mode rate
    always #62.5 lclk = ~lclk;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // One bit: data set in the low phase, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        @(posedge lclk) sda_low <= !b;
        @(posedge lclk) scl <= 1'b1;
        @(posedge lclk) r = sda;
        @(posedge lclk) scl <= 1'b0;
    endtask : bit_io
    // START; from a low scl it serves as a repeated START
    task automatic start_c();
        @(posedge lclk) sda_low <= 1'b0;
        @(posedge lclk) scl <= 1'b1;
        @(posedge lclk) sda_low <= 1'b1;
        @(posedge lclk) scl <= 1'b0;
    endtask : start_c
    // STOP: data rises while scl is high
    task automatic stop_c();
        @(posedge lclk) sda_low <= 1'b1;
        @(posedge lclk) scl <= 1'b1;
        @(posedge lclk) sda_low <= 1'b0;
    endtask : stop_c
    // Byte out MSB first; ack is a low ninth slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte
    // Byte in MSB first; ACK asks for more, NACK ends it
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask : rbyte
endmodule : ita_master

// >>> tb/test_ita_target.sv
// Purpose: Self-checking bench for the serial register target
// Assumes: The master model owns scl and its share of sda
// Notes: Each scenario except t_reset runs whole transactions and judges them
`timescale 1ns/100ps
module test_ita_target;
    // Identification image; values arbitrary
    localparam logic [71:0] ID_V = 72'h9a_89_78_67_56_45_34_23_12;
    // Register 50 is one-to-clear, reset to ff; register 51 is write-only
    localparam logic [ita_pkg::REG_COUNT-1:0][7:0] RST_IMG =
        2048'hff << 640;
    localparam logic [ita_pkg::REG_COUNT-1:0] W1C_M = 256'h1 << 8'h50;
    localparam logic [ita_pkg::REG_COUNT-1:0] WO_M = 256'h1 << 8'h51;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic chip_en = 1'b1;
    logic tgt_sel = 1'b1;
    logic scl, sda_low, sda_o, sda_oe, sda;
    logic [ita_pkg::REG_COUNT-1:0][7:0] csr_q;
    logic [ita_pkg::REG_COUNT-1:0][7:0] status_set = '0;
    int n_fail = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////
    // Pulled-up wire; either party may pull it low
    assign sda = !((sda_oe && !sda_o) || sda_low);
    always #5 clk = ~clk;
    ita_target #(.ID_BYTES(ID_V), .RESET_IMAGE(RST_IMG),
        .W1C_REGS(W1C_M), .WO_REGS(WO_M)) i_dut (
        .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .chip_en(chip_en), .tgt_sel(tgt_sel),
        .csr_q(csr_q), .status_set(status_set)
    );
    ita_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Send a byte and judge the acknowledge
    task automatic wr(input logic [7:0] b, input logic ea);
        logic a;
        i_mst.wbyte(b, a);
        check("ack", {7'h0, ea}, {7'h0, a});
    endtask : wr
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // Identification bytes and released sda_oe straight after reset
    task automatic t_reset();
        for (int k = 0; k < 9; k++) begin
            check("ident", ID_V[k*8+:8], csr_q[k]);
        end
        check("sda_oe", 8'h00, {7'h0, sda_oe});
    endtask : t_reset
    // Both straps; first reads start at 00h and advance
    task automatic t_addr();
        logic [7:0] d;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk) tgt_sel <= s[0];
            repeat (4) @(posedge clk);
            i_mst.start_c();
            wr(s ? 8'h5a : 8'h58, 1'b1);
            i_mst.start_c();
            wr(s ? 8'h58 : 8'h5a, 1'b0);
            i_mst.start_c();
            wr(s ? 8'h5b : 8'h59, 1'b1);
            i_mst.rbyte(1'b0, d);
            check("first read", ID_V[s*8+:8], d);
            i_mst.stop_c();
        end
    endtask : t_addr
    // Burst write, then set the start point and read it back
    task automatic t_burst();
        logic [7:0] d;
        i_mst.start_c();
        wr(8'h5a, 1'b1);
        wr(8'h40, 1'b1);
        wr(8'ha5, 1'b1);
        wr(8'h3c, 1'b1);
        i_mst.stop_c();
        repeat (4) @(posedge clk);
        check("reg 40", 8'ha5, csr_q[8'h40]);
        check("reg 41", 8'h3c, csr_q[8'h41]);
        i_mst.start_c();
        wr(8'h5a, 1'b1);
        wr(8'h40, 1'b1);
        i_mst.stop_c();
        i_mst.start_c();
        wr(8'h5b, 1'b1);
        i_mst.rbyte(1'b1, d);
        check("read 40", 8'ha5, d);
        i_mst.rbyte(1'b0, d);
        check("read 41", 8'h3c, d);
        repeat (10) @(posedge clk);
        check("release", 8'h00, {7'h0, sda_oe});
        i_mst.stop_c();
    endtask : t_burst
    // Chip enable low: the own address goes unanswered
    task automatic t_off();
        @(posedge clk) chip_en <= 1'b0;
        repeat (4) @(posedge clk);
        i_mst.start_c();
        wr(8'h5a, 1'b0);
        i_mst.stop_c();
        @(posedge clk) chip_en <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : t_off
    // Last identification byte ignores a write; the next one takes it
    task automatic t_ident();
        i_mst.start_c();
        wr(8'h5a, 1'b1);
        wr(8'h08, 1'b1);
        wr(8'hc3, 1'b1);
        wr(8'h5e, 1'b1);
        i_mst.stop_c();
        repeat (4) @(posedge clk);
        check("ident 8", ID_V[71:64], csr_q[8]);
        check("reg 9", 8'h5e, csr_q[9]);
    endtask : t_ident
    // One-to-clear and write-only registers, whole bytes only
    task automatic t_access();
        logic [7:0] d;
        i_mst.start_c();
        wr(8'h5a, 1'b1);
        wr(8'h50, 1'b1);
        wr(8'h30, 1'b1);
        wr(8'h77, 1'b1);
        i_mst.stop_c();
        i_mst.start_c();
        wr(8'h5a, 1'b1);
        wr(8'h50, 1'b1);
        i_mst.start_c();
        wr(8'h5b, 1'b1);
        i_mst.rbyte(1'b1, d);
        check("read 50", 8'hcf, d);
        i_mst.rbyte(1'b0, d);
        check("read 51", 8'h00, d);
        i_mst.stop_c();
        check("reg 51", 8'h77, csr_q[8'h51]);
    endtask : t_access
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_addr();
        t_burst();
        t_off();
        t_ident();
        t_access();
        give_verdict();
    end
endmodule : test_ita_target
